// [inc/pacs_pkg.sv]
`default_nettype none
package pacs_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INTERVAL = 8'h04;
   localparam logic [7:0] ADDR_FREQ_LIM = 8'h08;
   localparam logic [7:0] ADDR_RELAY_SEL = 8'h0C;
   localparam logic [7:0] ADDR_INPUT_SEL = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // ==========================================================
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MAXAUX_LSB = 4;
   localparam int SEL_STRIDE = 8;
   localparam int INSEL_LOCK3_BIT = 16;
   localparam int ST_ORDER_LSB = 0;
   localparam int ST_AVAIL_LSB = 8;
   localparam int ST_MOTOR_LSB = 12;
   localparam int ST_STOP_BIT = 16;
   localparam int ST_EXPIRED_BIT = 17;
   localparam int ST_ROTCNT_LSB = 24;
   // ==========================================================
   // mode and function codes
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_AUX = 3'h1;
   localparam logic [2:0] MODE_ALL = 3'h2;
   localparam logic [2:0] MODE_AUX_LOCK = 3'h3;
   localparam logic [2:0] MODE_ALL_LOCK = 3'h4;
   localparam logic [4:0] ROT_OUT_CODE_BASE = 5'h11;
   localparam logic [4:0] LOCK_ONE_CODE = 5'h0A;
   localparam logic [4:0] LOCK_TWO_CODE = 5'h0D;
   // ==========================================================
   // reset values
   localparam logic [2:0] CTRL_MODE_RST = 3'h0;
   localparam logic [1:0] CTRL_MAXAUX_RST = 2'h2;
   localparam logic [31:0] INTERVAL_RST = 32'h0001_0000;
   localparam logic [15:0] FREQ_LIM_RST = 16'h0000;
   localparam logic [5:0] ORDER_RST = 6'h24;
   localparam logic [1:0] VS_NONE = 2'h3;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int STOP_GAP_NS = 400;
   localparam logic [3:0] STOP_GAP_CYC = 4'((STOP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ==========================================================
   // state
   typedef enum logic [1:0] {ST_RUN, ST_STOP} pacs_state_type;
   typedef struct packed {
      pacs_state_type st;
      logic [3:0] gap;
      logic [5:0] order;
      logic [1:0] vs;
      logic [2:0] motorOn;
      logic [2:0] avail;
      logic [2:0] relay;
      logic [7:0] rotCnt;
      logic [2:0] mode;
      logic [1:0] maxAux;
      logic [31:0] interval;
      logic [15:0] freqLim;
      logic [14:0] relSel;
      logic [10:0] inSel;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pacs_top_state_type;
   typedef struct packed {
      logic [31:0] count;
      logic expired;
   } pacs_tmr_state_type;
endpackage : pacs_pkg
`default_nettype wire

// [inc/pacs_tmr_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface pacs_tmr_if;
   logic run;
   logic clr;
   logic [31:0] interval;
   logic expired;
   logic [31:0] count;
   modport ctl(output run, output clr, output interval, input expired, input count);
   modport tmr(input run, input clr, input interval, output expired, output count);
endinterface : pacs_tmr_if
`default_nettype wire

// [src/pacs_interval_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module pacs_interval_timer (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // control side
   pacs_tmr_if.tmr tmr
);
   pacs_pkg::pacs_tmr_state_type s_q, s_d;
   logic [31:0] cntNext;

   // ==========================================================
   // interval count
   always_comb begin
      s_d = s_q;
      cntNext = s_q.count + 32'h0000_0001;
      if (!tmr.run || tmr.clr) begin
         s_d.count = 32'h0000_0000;
         s_d.expired = 1'b0;
      end else if (!s_q.expired) begin
         s_d.count = cntNext;
         s_d.expired = (cntNext >= tmr.interval);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tmr.expired = s_q.expired;
   assign tmr.count = s_q.count;

   // ==========================================================
   // checks
   timerIdle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !tmr.run |=> (s_q.count == 32'h0000_0000) && !s_q.expired)
      else $error("interval count moved without start request");
   timerClear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      tmr.clr |=> s_q.count == 32'h0000_0000)
      else $error("interval count not cleared after rotation");
   timerStep_a: assert property (@(posedge mclk) disable iff (sys_rst)
      tmr.run && !tmr.clr && !s_q.expired |=> s_q.count == $past(s_q.count) + 32'h0000_0001)
      else $error("interval count did not advance");
endmodule : pacs_interval_timer
`default_nettype wire

// [src/pacs_sequencer.sv]
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pacs_sequencer (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // process inputs
   input wire logic runRequestInput,
   input wire logic lockInputOne,
   input wire logic lockInputTwo,
   input wire logic lockInputThree,
   input wire logic sleeping,
   input wire logic [1:0] auxDemand,
   input wire logic [15:0] outFreq,
   // contactor relays
   output logic relayOutOne,
   output logic relayOutTwo,
   output logic relayOutThree
);
   pacs_pkg::pacs_top_state_type s_q, s_d;
   pacs_tmr_if tmrBus ();

   logic lockMode, rotMode, allMode, permit, rotate, vsLost, lockBack, apbAcc;
   logic [2:0] lockIn, onCalc;
   logic [1:0] vsCalc, auxRun, motorIdx;
   logic [2:0] needed, taken;
   logic [5:0] shifted;
   logic [4:0] selCode;

   pacs_interval_timer u_timer (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tmr(tmrBus.tmr)
   );

   // distance from the lock three enable register bit down to its place in the packed select copy
   localparam int SEL_OFF = 6;

   // ==========================================================
   // mode decode and availability
   always_comb begin
      lockMode = (s_q.mode == pacs_pkg::MODE_AUX_LOCK) || (s_q.mode == pacs_pkg::MODE_ALL_LOCK);
      allMode = (s_q.mode == pacs_pkg::MODE_ALL) || (s_q.mode == pacs_pkg::MODE_ALL_LOCK);
      rotMode = (s_q.mode != pacs_pkg::MODE_OFF) && (s_q.mode <= pacs_pkg::MODE_ALL_LOCK);
      // lock three comes from the analog pin used as a digital input
      lockIn[0] = lockInputOne && (s_q.inSel[4:0] == pacs_pkg::LOCK_ONE_CODE);
      lockIn[1] = lockInputTwo && (s_q.inSel[9:5] == pacs_pkg::LOCK_TWO_CODE);
      lockIn[2] = lockInputThree && s_q.inSel[pacs_pkg::INSEL_LOCK3_BIT - SEL_OFF];
   end

   // ==========================================================
   // capacity check
   always_comb begin
      auxRun = 2'h0;
      if (s_q.motorOn != 3'b000) begin
         auxRun = 2'(s_q.motorOn[0] + s_q.motorOn[1] + s_q.motorOn[2] - 1);
      end
      if (s_q.freqLim == 16'h0000) begin
         permit = !runRequestInput || sleeping;
      end else begin
         permit = (auxRun < s_q.maxAux)
            || ((auxRun == s_q.maxAux) && (outFreq < s_q.freqLim));
      end
      // expired flag holds in the timer until permit, so rotation waits
      rotate = rotMode && tmrBus.expired && permit && (s_q.st == pacs_pkg::ST_RUN);
      vsLost = lockMode && (s_q.vs != pacs_pkg::VS_NONE) && !s_q.avail[s_q.vs]
         && (s_q.st == pacs_pkg::ST_RUN);
      lockBack = lockMode && runRequestInput && ((s_q.avail & ~s_q.motorOn & ~s_q.avail) == 3'b000)
         && ((lockMode ? lockIn : 3'b111) & ~s_q.avail) != 3'b000;
      if (allMode) begin
         shifted = {s_q.order[1:0], s_q.order[5:4], s_q.order[3:2]};
      end else begin
         shifted = {s_q.order[3:2], s_q.order[5:4], s_q.order[1:0]};
      end
   end

   // ==========================================================
   // motor assignment walk over the start order
   always_comb begin
      onCalc = 3'b000;
      vsCalc = pacs_pkg::VS_NONE;
      taken = 3'h0;
      motorIdx = 2'h0;
      needed = (runRequestInput && !sleeping) ? 3'(auxDemand) + 3'h1 : 3'h0;
      for (int p = 0; p < 3; p++) begin
         motorIdx = s_q.order[2 * p +: 2];
         if (s_q.avail[motorIdx] && (taken < needed)) begin
            onCalc[motorIdx] = 1'b1;
            if (taken == 3'h0) begin
               vsCalc = motorIdx;
            end
            taken = taken + 3'h1;
         end
      end
   end

   // ==========================================================
   // sequence, relays and registers
   always_comb begin
      s_d = s_q;
      selCode = 5'h00;
      apbAcc = psel && penable && !s_q.pready;
      s_d.avail = lockMode ? lockIn : 3'b111;
      unique case (s_q.st)
         pacs_pkg::ST_RUN: begin
            if (rotate || vsLost || lockBack) begin
               s_d.st = pacs_pkg::ST_STOP;
               s_d.gap = pacs_pkg::STOP_GAP_CYC;
               s_d.motorOn = 3'b000;
               s_d.vs = pacs_pkg::VS_NONE;
               if (rotate) begin
                  s_d.order = shifted;
                  s_d.rotCnt = s_q.rotCnt + 8'h01;
               end
            end else begin
               // a lost aux is simply replaced by the walk, vs motor untouched
               s_d.motorOn = onCalc;
               s_d.vs = vsCalc;
            end
         end
         pacs_pkg::ST_STOP: begin
            s_d.motorOn = 3'b000;
            s_d.gap = s_q.gap - 4'h1;
            if (s_q.gap == 4'h1) begin
               s_d.st = pacs_pkg::ST_RUN;
            end
         end
      endcase
      for (int k = 0; k < 3; k++) begin
         selCode = s_q.relSel[5 * k +: 5];
         s_d.relay[k] = 1'b0;
         for (int j = 0; j < 3; j++) begin
            if (selCode == 5'(pacs_pkg::ROT_OUT_CODE_BASE + 5'(j))) begin
               s_d.relay[k] = s_d.motorOn[j] && s_d.avail[j];
            end
         end
      end
      s_d.pready = apbAcc;
      s_d.pslverr = 1'b0;
      if (apbAcc) begin
         s_d.prdata = 32'h0000_0000;
         unique case (paddr)
            pacs_pkg::ADDR_CTRL: begin
               s_d.prdata[2:0] = s_q.mode;
               s_d.prdata[5:4] = s_q.maxAux;
               if (pwrite) begin
                  s_d.mode = pwdata[pacs_pkg::CTRL_MODE_LSB +: 3];
                  s_d.maxAux = pwdata[pacs_pkg::CTRL_MAXAUX_LSB +: 2];
               end
            end
            pacs_pkg::ADDR_INTERVAL: begin
               s_d.prdata = s_q.interval;
               if (pwrite) begin
                  s_d.interval = pwdata;
               end
            end
            pacs_pkg::ADDR_FREQ_LIM: begin
               s_d.prdata[15:0] = s_q.freqLim;
               if (pwrite) begin
                  s_d.freqLim = pwdata[15:0];
               end
            end
            pacs_pkg::ADDR_RELAY_SEL: begin
               for (int k = 0; k < 3; k++) begin
                  s_d.prdata[pacs_pkg::SEL_STRIDE * k +: 5] = s_q.relSel[5 * k +: 5];
                  if (pwrite) begin
                     s_d.relSel[5 * k +: 5] = pwdata[pacs_pkg::SEL_STRIDE * k +: 5];
                  end
               end
            end
            pacs_pkg::ADDR_INPUT_SEL: begin
               s_d.prdata[4:0] = s_q.inSel[4:0];
               s_d.prdata[12:8] = s_q.inSel[9:5];
               s_d.prdata[pacs_pkg::INSEL_LOCK3_BIT] = s_q.inSel[10];
               if (pwrite) begin
                  s_d.inSel = {pwdata[pacs_pkg::INSEL_LOCK3_BIT], pwdata[12:8], pwdata[4:0]};
               end
            end
            pacs_pkg::ADDR_STATUS: begin
               s_d.prdata[pacs_pkg::ST_ORDER_LSB +: 6] = s_q.order;
               s_d.prdata[pacs_pkg::ST_AVAIL_LSB +: 3] = s_q.avail;
               s_d.prdata[pacs_pkg::ST_MOTOR_LSB +: 3] = s_q.motorOn;
               s_d.prdata[pacs_pkg::ST_STOP_BIT] = (s_q.st == pacs_pkg::ST_STOP);
               s_d.prdata[pacs_pkg::ST_EXPIRED_BIT] = tmrBus.expired;
               s_d.prdata[pacs_pkg::ST_ROTCNT_LSB +: 8] = s_q.rotCnt;
            end
            default: begin
               s_d.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.st <= pacs_pkg::ST_RUN;
         s_q.order <= pacs_pkg::ORDER_RST;
         s_q.vs <= pacs_pkg::VS_NONE;
         s_q.avail <= 3'b111;
         s_q.mode <= pacs_pkg::CTRL_MODE_RST;
         s_q.maxAux <= pacs_pkg::CTRL_MAXAUX_RST;
         s_q.interval <= pacs_pkg::INTERVAL_RST;
         s_q.freqLim <= pacs_pkg::FREQ_LIM_RST;
         s_q.relSel <= {5'h13, 5'h12, 5'h11};
         s_q.inSel <= {1'b1, pacs_pkg::LOCK_TWO_CODE, pacs_pkg::LOCK_ONE_CODE};
      end else begin
         s_q <= s_d;
      end
   end

   assign tmrBus.run = runRequestInput;
   assign tmrBus.clr = rotate;
   assign tmrBus.interval = s_q.interval;
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign relayOutOne = s_q.relay[0];
   assign relayOutTwo = s_q.relay[1];
   assign relayOutThree = s_q.relay[2];

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   lockIgnore_a: assert property (s_q.avail != 3'b111 |-> $past(lockMode))
      else $error("interlock used outside lock modes");
   rotateGate_a: assert property ($changed(s_q.order) |-> $past(tmrBus.expired && permit))
      else $error("order changed without expiry and capacity");
   rotateStop_a: assert property (rotate |=> (s_q.motorOn == 3'b000) [*8])
      else $error("motors not stopped on rotation");
   vsOn_a: assert property (s_q.vs != pacs_pkg::VS_NONE |-> s_q.motorOn[s_q.vs])
      else $error("variable-speed motor not switched on");
   onlyAvail_a: assert property ((s_q.motorOn & ~$past(s_q.avail)) == 3'b000)
      else $error("unavailable motor assigned");
   vsLoss_a: assert property (vsLost |=> s_q.st == pacs_pkg::ST_STOP)
      else $error("no stop after vs motor lost interlock");
   zeroLimit_a: assert property (rotate && s_q.freqLim == 16'h0000
      |-> !runRequestInput || sleeping)
      else $error("rotation while running with zero limit");
   shiftOrder_a: assert property (rotate && allMode
      |=> s_q.order == {$past(s_q.order[1:0]), $past(s_q.order[5:2])})
      else $error("order not shifted by one");
   gapEnd_a: assert property ($rose(s_q.st == pacs_pkg::ST_STOP)
      |-> ##10 s_q.st == pacs_pkg::ST_RUN)
      else $error("stop gap length wrong");

   rotSeen_c: cover property (rotate);
   deferSeen_c: cover property (tmrBus.expired && !permit ##[1:50] rotate);
   lockBackSeen_c: cover property (lockBack ##1 s_q.st == pacs_pkg::ST_STOP);
   vsLostSeen_c: cover property (vsLost);
endmodule : pacs_sequencer
`default_nettype wire

// [tb/pacs_motor_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pacs_motor_model (
   // clock
   input wire logic mclk,
   // relays from the sequencer
   input wire logic relayOutOne,
   input wire logic relayOutTwo,
   input wire logic relayOutThree,
   // switch states commanded by the bench
   input wire logic [2:0] switchOk,
   // interlock feedback
   output logic lockInputOne,
   output logic lockInputTwo,
   output logic lockInputThree,
   // motors that really turn
   output logic [2:0] motorRuns
);
   // ==========================================================
   // motor switches and contactors
   logic [2:0] closed_q;
   assign lockInputOne = switchOk[0];
   assign lockInputTwo = switchOk[1];
   assign lockInputThree = switchOk[2];
   always_ff @(posedge mclk) begin
      closed_q <= {relayOutThree, relayOutTwo, relayOutOne};
   end
   // a closed contactor turns nothing when its switch is open
   assign motorRuns = closed_q & switchOk;
endmodule : pacs_motor_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} pacs_note_type;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic runReq = 1'b0;
   logic sleeping = 1'b0;
   logic [1:0] auxDemand = 2'h0;
   logic [15:0] outFreq = 16'h0000;
   logic [2:0] switchOk = 3'h7;
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wire logic lockOne;
   wire logic lockTwo;
   wire logic lockThree;
   wire logic relayOutOne;
   wire logic relayOutTwo;
   wire logic relayOutThree;
   wire logic [2:0] motorRuns;
   wire logic [2:0] relays;
   int fails = 0;
   int compares = 0;
   int seed = 56360;
   pacs_note_type notes[$];
   pacs_note_type got;
   assign relays = {relayOutThree, relayOutTwo, relayOutOne};
   always #20 mclk = ~mclk;
   // ==========================================================
   // design and far side
   pacs_sequencer pacs_sequencer_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .runRequestInput(runReq), .lockInputOne(lockOne),
      .lockInputTwo(lockTwo), .lockInputThree(lockThree), .sleeping(sleeping),
      .auxDemand(auxDemand), .outFreq(outFreq), .relayOutOne(relayOutOne),
      .relayOutTwo(relayOutTwo), .relayOutThree(relayOutThree));
   pacs_motor_model pacs_motor_model_i (.mclk(mclk), .relayOutOne(relayOutOne),
      .relayOutTwo(relayOutTwo), .relayOutThree(relayOutThree), .switchOk(switchOk),
      .lockInputOne(lockOne), .lockInputTwo(lockTwo), .lockInputThree(lockThree),
      .motorRuns(motorRuns));
   // ==========================================================
   // helpers
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
      input logic [31:0] exp, input logic [31:0] mask, input logic err);
      int n;
      pacs_note_type note;
      note.exp = exp;
      note.mask = mask;
      note.err = err;
      notes.push_back(note);
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         check(32'h0, 32'h1);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask);
      apb(1'b0, addr, 32'h0, exp, mask, 1'b0);
   endtask : rd
   task wr(input logic [7:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data, 32'h0, 32'h0, 1'b0);
   endtask : wr
   task idle(input int k);
      repeat (k) @(posedge mclk);
   endtask : idle
   // waits for a relay pattern while the motors in keep must go on turning
   task wait_relays(input logic [2:0] exp, input int lim, input logic [2:0] keep);
      int n;
      n = 0;
      @(negedge mclk);
      while (relays !== exp && n < lim) begin
         if (keep != 3'h0) begin
            check({29'h0, motorRuns & keep}, {29'h0, keep});
         end
         @(negedge mclk);
         n++;
      end
      check({29'h0, relays}, {29'h0, exp});
   endtask : wait_relays
   // ==========================================================
   // result watcher
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (notes.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            got = notes.pop_front();
            check(prdata & got.mask, got.exp & got.mask);
            check({31'h0, pslverr}, {31'h0, got.err});
         end
      end
   end
   initial begin
      idle(20000);
      fails++;
      report_and_stop();
   end
   // ==========================================================
   // scenarios
   initial begin
      idle(4);
      sys_rst <= 1'b0;
      rd(pacs_pkg::ADDR_CTRL, 32'h0000_0020, 32'hFFFF_FFFF);
      rd(pacs_pkg::ADDR_INTERVAL, 32'h0001_0000, 32'hFFFF_FFFF);
      rd(pacs_pkg::ADDR_FREQ_LIM, 32'h0, 32'hFFFF_FFFF);
      rd(pacs_pkg::ADDR_RELAY_SEL, 32'h0013_1211, 32'hFFFF_FFFF);
      rd(pacs_pkg::ADDR_INPUT_SEL, 32'h0001_0D0A, 32'hFFFF_FFFF);
      apb(1'b0, 8'h3C, 32'h0, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'h18, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b1);
      wr(pacs_pkg::ADDR_STATUS, 32'h0);
      rd(pacs_pkg::ADDR_STATUS, 32'h0000_0024, 32'h0000_003F);
      wr(pacs_pkg::ADDR_INTERVAL, 32'd20);
      wr(pacs_pkg::ADDR_FREQ_LIM, 32'h0000_0100);
      runReq <= 1'b1;
      auxDemand <= 2'h2;
      for (int m = 0; m < 2; m++) begin
         wr(pacs_pkg::ADDR_CTRL, (m == 0) ? 32'h0000_0020 : 32'h0000_0025);
         idle(60);
         rd(pacs_pkg::ADDR_STATUS, 32'h0, 32'hFF00_0000);
      end
      runReq <= 1'b0;
      wr(pacs_pkg::ADDR_CTRL, 32'h0000_0022);
      runReq <= 1'b1;
      wait_relays(3'h7, 40, 3'h0);
      wait_relays(3'h0, 60, 3'h0);
      @(posedge mclk);
      outFreq <= 16'h0100 + 16'($unsigned($random(seed)) % 256);
      repeat (8) begin
         @(negedge mclk);
         check({29'h0, relays}, 32'h0);
      end
      wait_relays(3'h7, 20, 3'h0);
      rd(pacs_pkg::ADDR_STATUS, 32'h0100_0009, 32'hFF00_003F);
      idle(40);
      rd(pacs_pkg::ADDR_STATUS, 32'h0102_0009, 32'hFF02_003F);
      @(posedge mclk);
      outFreq <= 16'($unsigned($random(seed)) % 256);
      wait_relays(3'h0, 10, 3'h0);
      @(posedge mclk);
      outFreq <= 16'h0100 + 16'($unsigned($random(seed)) % 256);
      wait_relays(3'h7, 30, 3'h0);
      rd(pacs_pkg::ADDR_STATUS, 32'h0200_0012, 32'hFF00_003F);
      wr(pacs_pkg::ADDR_CTRL, 32'h0000_0032);
      wait_relays(3'h0, 40, 3'h0);
      wait_relays(3'h7, 30, 3'h0);
      rd(pacs_pkg::ADDR_STATUS, 32'h0300_0024, 32'hFF00_003F);
      runReq <= 1'b0;
      wait_relays(3'h0, 4, 3'h0);
      idle(40);
      rd(pacs_pkg::ADDR_STATUS, 32'h0300_0000, 32'hFF02_0000);
      wr(pacs_pkg::ADDR_CTRL, 32'h0000_0022);
      wr(pacs_pkg::ADDR_FREQ_LIM, 32'h0);
      runReq <= 1'b1;
      idle(60);
      rd(pacs_pkg::ADDR_STATUS, 32'h0300_0000, 32'hFF00_0000);
      sleeping <= 1'b1;
      idle(10);
      rd(pacs_pkg::ADDR_STATUS, 32'h0400_0009, 32'hFF00_003F);
      sleeping <= 1'b0;
      auxDemand <= 2'h1;
      wr(pacs_pkg::ADDR_CTRL, 32'h0000_0024);
      wait_relays(3'h6, 40, 3'h0);
      switchOk <= 3'h3;
      wait_relays(3'h3, 8, 3'h2);
      switchOk <= 3'h7;
      wait_relays(3'h0, 6, 3'h0);
      wait_relays(3'h6, 30, 3'h0);
      switchOk <= 3'h5;
      wait_relays(3'h0, 6, 3'h0);
      wait_relays(3'h5, 30, 3'h0);
      auxDemand <= 2'h2;
      wr(pacs_pkg::ADDR_CTRL, 32'h0000_0022);
      wait_relays(3'h7, 40, 3'h0);
      wr(pacs_pkg::ADDR_FREQ_LIM, 32'h0000_0100);
      wr(pacs_pkg::ADDR_CTRL, 32'h0000_0031);
      wait_relays(3'h0, 40, 3'h0);
      wait_relays(3'h7, 30, 3'h0);
      rd(pacs_pkg::ADDR_STATUS, 32'h0500_0021, 32'hFF00_003F);
      idle(2);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
